/* File: rtl/time_event_pkg.sv */
// Package with register offsets, field positions, reset values and widths for the pin event block.
// Assumes a 32-bit register port with byte addresses on the system clock.
package time_event_pkg;
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_UNIT_INDEX = 12'h520;
    localparam logic [11:0] OFS_IRQ_STATUS = 12'h528;
    localparam logic [11:0] OFS_CTRL_STATUS = 12'h52c;
    localparam logic [11:0] OFS_UNIT_TRIGGER = 12'h540;
    localparam logic [11:0] OFS_UNIT_CONFIG = 12'h544;
    localparam int PULSE_UNITS = 3;
    localparam int CAPTURE_UNITS = 2;
    localparam int PULSE_FLAG_LSB = 16;
    localparam int CAPTURE_FLAG_LSB = 0;
    localparam int BIT_CAP_ARM = 1;
    localparam int BIT_SOFT_CLEAR = 2;
    localparam int BIT_PULSE_ARM = 3;
    localparam int BIT_PULSE_ACTIVE = 4;
    localparam int BIT_CAP_IRQ_EN = 5;
    localparam int BIT_DIRECTION = 6;
    localparam int BIT_PIN_LEVEL = 7;
    localparam int BIT_OUT_SRC = 8;
    localparam int BIT_CAP_SELECT = 8;
    localparam int BIT_NOTIFY = 0;
    localparam int BIT_LEVEL = 1;
    localparam int CAP_COUNT_W = 4;
    localparam logic [1:0] PULSE_SEL_RESERVED = 2'h3;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
endpackage

/* File: rtl/pulse_unit_if.sv */
// Interface carrying one pulse unit's controls and status between the register file and unit.
// Assumes all signals sample on the system clock.
interface pulse_unit_if;
    logic arm_set;
    logic arm_clear;
    logic soft_clear;
    logic notify;
    logic level;
    logic fire;
    logic late;
    logic armed;
    logic active;
    logic done_evt;
    logic error_evt;
    logic out_level;
    modport ctrl (output arm_set, arm_clear, soft_clear, notify, level, fire, late,
        input armed, active, done_evt, error_evt, out_level);
    modport unit (input arm_set, arm_clear, soft_clear, notify, level, fire, late,
        output armed, active, done_evt, error_evt, out_level);
endinterface

/* File: rtl/pulse_unit.sv */
// One pulse-output unit: arm, fire, late error and soft clear.
// Assumes the fire and late inputs come from the time comparator outside.
module pulse_unit
    import time_event_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    pulse_unit_if.unit pu
);
    logic armed_reg;
    logic err_reg;
    logic out_reg;
    logic done_reg;
    logic errevt_reg;

    wire logic fire_now = armed_reg && pu.fire && !pu.late;
    wire logic late_now = armed_reg && pu.late && !err_reg;

    always_ff @(posedge clk_sys) begin
        if (sys_rst || pu.soft_clear) begin // R12 R13
            armed_reg <= 1'b0;
            err_reg <= 1'b0;
            out_reg <= 1'b0;
            done_reg <= 1'b0;
            errevt_reg <= 1'b0;
        end else begin
            if (pu.arm_clear) begin
                armed_reg <= 1'b0;
                err_reg <= 1'b0; // R18
            end else if (pu.arm_set) begin
                armed_reg <= 1'b1;
            end else if (fire_now) begin
                armed_reg <= 1'b0; // R10
            end
            if (late_now && !pu.arm_clear) begin
                err_reg <= 1'b1; // R18
            end
            if (fire_now) begin
                out_reg <= pu.level;
            end
            done_reg <= fire_now && pu.notify; // R03
            errevt_reg <= late_now && pu.notify; // R03 R18
        end
    end

    assign pu.armed = armed_reg;
    assign pu.active = armed_reg && !err_reg; // R09
    assign pu.done_evt = done_reg;
    assign pu.error_evt = errevt_reg;
    assign pu.out_level = out_reg;
endmodule

/* File: rtl/gpio_time_event_ctrl.sv */
// Pin control and interrupt status for three pulse-output and two capture units.
// Assumes a one-cycle register port and a time comparator supplying fire and late strobes.
// Notes on behaviour
// R01: Summary interrupt is OR of flags.
// R02: Bits 18:16 pulse flags, write clears.
// R03: Pulse flag raised only when reporting enabled.
// R04: Bits 1:0 capture flags, write clears.
// R05: Bit 5 enables selected capture interrupt.
// R06: Bit 8 picks combinational or registered output.
// R07: Bit 7 reads pin level.
// R08: Bit 6 sets capture input or output.
// R09: Bit 4 shows selected pulse unit active.
// R10: Bit 3 arms pulse unit, self-clears.
// R11: Software arms only head of chain.
// R12: Bit 2 soft-clears selected pulse unit.
// R13: Soft clear halts endless cascade chain.
// R14: Writing arm one clears event counter.
// R15: Writing arm zero clears valid, overflow.
// R16: Index pointers select target unit.
// R17: Pulse index 11 is reserved.
// R18: Late error set; cleared by disarming.
// R19: Reserved bits read zero, writes ignored.
module gpio_time_event_ctrl
    import time_event_pkg::*;
#(
    parameter int NUM_PULSE = PULSE_UNITS,
    parameter int NUM_CAPTURE = CAPTURE_UNITS
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [NUM_PULSE-1:0] pulse_fire,
    input wire logic [NUM_PULSE-1:0] pulse_late,
    input wire logic [NUM_CAPTURE-1:0] capture_event,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    output logic pin_event_irq
);
    logic [1:0] pulse_unit_select_reg;
    logic capture_unit_select_reg;
    logic out_src_reg;
    logic pin_direction_select_reg;
    logic [NUM_PULSE-1:0] notify_reg;
    logic [NUM_PULSE-1:0] level_reg;
    logic [NUM_PULSE-1:0] pulse_flag_reg;
    logic [NUM_CAPTURE-1:0] capture_flag_reg;
    logic [NUM_CAPTURE-1:0] capture_irq_enable_reg;
    logic [NUM_CAPTURE-1:0] capture_unit_arm_reg;
    logic [NUM_CAPTURE-1:0] capture_result_valid_reg;
    logic [NUM_CAPTURE-1:0] capture_count_overflow_reg;
    logic [CAP_COUNT_W-1:0] capture_event_count_reg [NUM_CAPTURE];
    logic [31:0] reg_rdata_reg;
    logic pin_out_reg;
    logic pin_oe_reg;
    logic irq_reg;
    logic pin_flop_reg;

    wire logic [NUM_PULSE-1:0] armed;
    wire logic [NUM_PULSE-1:0] active;
    wire logic [NUM_PULSE-1:0] done_evt;
    wire logic [NUM_PULSE-1:0] error_evt;
    wire logic [NUM_PULSE-1:0] out_level;

    wire logic wr_index = reg_wr && (reg_addr == OFS_UNIT_INDEX);
    wire logic wr_status = reg_wr && (reg_addr == OFS_IRQ_STATUS);
    wire logic wr_ctrl = reg_wr && (reg_addr == OFS_CTRL_STATUS);
    wire logic wr_cfg = reg_wr && (reg_addr == OFS_UNIT_CONFIG);
    wire logic pulse_sel_ok = (pulse_unit_select_reg != PULSE_SEL_RESERVED); // R17

    // Pulse unit picked by the index, none when the index is reserved.
    function automatic logic pulse_hit(input logic [1:0] sel, input int idx);
        pulse_hit = (sel != PULSE_SEL_RESERVED) && (sel == idx[1:0]); // R16 R17
    endfunction

    genvar g;
    generate
        for (g = 0; g < NUM_PULSE; g++) begin : g_pulse
            pulse_unit_if pu ();
            wire logic hit = pulse_hit(pulse_unit_select_reg, g);
            assign pu.arm_set = wr_ctrl && hit && reg_wdata[BIT_PULSE_ARM]; // R10
            assign pu.arm_clear = wr_ctrl && hit && !reg_wdata[BIT_PULSE_ARM]; // R18
            assign pu.soft_clear = wr_ctrl && hit && reg_wdata[BIT_SOFT_CLEAR]; // R12 R13
            assign pu.notify = notify_reg[g];
            assign pu.level = level_reg[g];
            assign pu.fire = pulse_fire[g];
            assign pu.late = pulse_late[g];
            assign armed[g] = pu.armed;
            assign active[g] = pu.active;
            assign done_evt[g] = pu.done_evt;
            assign error_evt[g] = pu.error_evt;
            assign out_level[g] = pu.out_level;
            pulse_unit u_unit (
                .clk_sys(clk_sys),
                .sys_rst(sys_rst),
                .pu(pu)
            );

            always_ff @(posedge clk_sys) begin
                if (sys_rst || pu.soft_clear) begin
                    notify_reg[g] <= 1'b0;
                    level_reg[g] <= 1'b0;
                end else if (wr_cfg && hit) begin
                    notify_reg[g] <= reg_wdata[BIT_NOTIFY];
                    level_reg[g] <= reg_wdata[BIT_LEVEL];
                end
            end

            // Set wins over a clear in the same cycle.
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    pulse_flag_reg[g] <= 1'b0;
                end else if (done_evt[g] || error_evt[g]) begin
                    pulse_flag_reg[g] <= 1'b1; // R02 R03
                end else if (wr_status && reg_wdata[PULSE_FLAG_LSB + g]) begin
                    pulse_flag_reg[g] <= 1'b0; // R02
                end
            end
        end

        for (g = 0; g < NUM_CAPTURE; g++) begin : g_cap
            wire logic hit = (capture_unit_select_reg == 1'(g)); // R16
            wire logic evt = capture_event[g] && capture_unit_arm_reg[g] &&
                pin_direction_select_reg; // R08
            wire logic cnt_full = &capture_event_count_reg[g];

            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    capture_unit_arm_reg[g] <= 1'b0;
                    capture_irq_enable_reg[g] <= 1'b0;
                    capture_result_valid_reg[g] <= 1'b0;
                    capture_count_overflow_reg[g] <= 1'b0;
                    capture_event_count_reg[g] <= '0;
                end else if (wr_ctrl && hit) begin
                    capture_unit_arm_reg[g] <= reg_wdata[BIT_CAP_ARM];
                    capture_irq_enable_reg[g] <= reg_wdata[BIT_CAP_IRQ_EN]; // R05
                    if (reg_wdata[BIT_CAP_ARM]) begin
                        capture_event_count_reg[g] <= '0; // R14
                    end else begin
                        capture_result_valid_reg[g] <= 1'b0; // R15
                        capture_count_overflow_reg[g] <= 1'b0; // R15
                    end
                end else if (evt) begin
                    capture_result_valid_reg[g] <= 1'b1;
                    if (cnt_full) begin
                        capture_count_overflow_reg[g] <= 1'b1;
                    end else begin
                        capture_event_count_reg[g] <= capture_event_count_reg[g] + 1'b1;
                    end
                end
            end

            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    capture_flag_reg[g] <= 1'b0;
                end else if (evt && capture_irq_enable_reg[g]) begin
                    capture_flag_reg[g] <= 1'b1; // R04 R05
                end else if (wr_status && reg_wdata[CAPTURE_FLAG_LSB + g]) begin
                    capture_flag_reg[g] <= 1'b0; // R04
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pulse_unit_select_reg <= 2'h0;
            capture_unit_select_reg <= 1'b0;
        end else if (wr_index) begin
            pulse_unit_select_reg <= reg_wdata[1:0]; // R16
            capture_unit_select_reg <= reg_wdata[BIT_CAP_SELECT]; // R16
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            out_src_reg <= 1'b0;
            pin_direction_select_reg <= 1'b0;
        end else if (wr_ctrl) begin
            out_src_reg <= reg_wdata[BIT_OUT_SRC]; // R06
            pin_direction_select_reg <= reg_wdata[BIT_DIRECTION]; // R08
        end
    end

    wire logic [1:0] psel = pulse_unit_select_reg;
    wire logic sel_armed = pulse_sel_ok && armed[psel];
    wire logic sel_active = pulse_sel_ok && active[psel];
    wire logic pulse_comb = |(out_level & armed) | (|(out_level));
    wire logic pin_drive = out_src_reg ? pulse_comb : pin_flop_reg; // R06

    wire logic [31:0] rd_status = {13'h0, pulse_flag_reg, 14'h0, capture_flag_reg}; // R19
    wire logic [31:0] rd_ctrl = {23'h0, out_src_reg, pin_in, pin_direction_select_reg,
        capture_irq_enable_reg[capture_unit_select_reg], sel_active, sel_armed, 1'b0,
        capture_unit_arm_reg[capture_unit_select_reg], 1'b0}; // R07 R09 R19
    wire logic [31:0] rd_index = {23'h0, capture_unit_select_reg, 6'h0, pulse_unit_select_reg};
    // Bits 7:2 show the selected capture unit's count, overflow and valid state.
    wire logic [31:0] rd_cfg = {24'h0, capture_event_count_reg[capture_unit_select_reg],
        capture_count_overflow_reg[capture_unit_select_reg],
        capture_result_valid_reg[capture_unit_select_reg], level_reg[psel] && pulse_sel_ok,
        notify_reg[psel] && pulse_sel_ok}; // R14 R15
    wire logic [31:0] rd_mux = (reg_addr == OFS_IRQ_STATUS) ? rd_status :
        (reg_addr == OFS_CTRL_STATUS) ? rd_ctrl :
        (reg_addr == OFS_UNIT_INDEX) ? rd_index :
        (reg_addr == OFS_UNIT_CONFIG) ? rd_cfg : REG_RESET;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            reg_rdata_reg <= REG_RESET;
            pin_flop_reg <= 1'b0;
            pin_out_reg <= 1'b0;
            pin_oe_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            reg_rdata_reg <= reg_rd ? rd_mux : REG_RESET;
            pin_flop_reg <= pulse_comb;
            pin_out_reg <= pin_drive;
            pin_oe_reg <= !pin_direction_select_reg; // R08
            irq_reg <= |pulse_flag_reg | (|capture_flag_reg); // R01
        end
    end

    assign reg_rdata = reg_rdata_reg;
    assign pin_out = pin_out_reg;
    assign pin_oe = pin_oe_reg;
    assign pin_event_irq = irq_reg;
endmodule

/* File: tb/pin_load.sv */
// Load model on the shared pin.
// Assumes a push-pull pin with no pull resistor.
module pin_load
(
    input wire logic pin_out,
    input wire logic pin_oe,
    input wire logic ext_level,
    output logic pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // The block owns the wire while it drives, otherwise the load does.
    assign pin_in = pin_oe ? pin_out : ext_level;
endmodule

/* File: tb/gpio_time_event_ctrl_asserts.sv */
// Checker on the ports of the pin event block.
// Assumes one clock domain and a synchronous active-high reset.
module gpio_time_event_ctrl_asserts
    import time_event_pkg::*;
#(parameter int NUM_PULSE = PULSE_UNITS, parameter int NUM_CAPTURE = CAPTURE_UNITS)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [NUM_PULSE-1:0] pulse_fire,
    input wire logic [NUM_PULSE-1:0] pulse_late,
    input wire logic [NUM_CAPTURE-1:0] capture_event,
    input wire logic pin_in,
    input wire logic pin_out,
    input wire logic pin_oe,
    input wire logic pin_event_irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic [3:0] since_evt;
    wire any_evt = (|pulse_fire) || (|pulse_late) || (|capture_event);
    wire rd_ctrl = reg_rd && reg_addr == OFS_CTRL_STATUS;
    always_ff @(posedge clk_sys) begin
        if (sys_rst || any_evt) begin
            since_evt <= 4'h0;
        end else if (since_evt != 4'hf) begin
            since_evt <= since_evt + 4'h1;
        end
    end
    property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    property p_unmapped; reg_rd && reg_addr == OFS_UNIT_TRIGGER |=> reg_rdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_irq_rsvd;
        reg_rd && reg_addr == OFS_IRQ_STATUS |=>
            reg_rdata[31:19] == 13'h0 && reg_rdata[15:2] == 14'h0;
    endproperty
    a_irq_rsvd: assert property (p_irq_rsvd) else $error("status reserved bits set");
    property p_ctrl_rsvd; rd_ctrl |=> reg_rdata[31:9] == 23'h0; endproperty
    a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("control reserved bits set");
    property p_pin_level; rd_ctrl |=> reg_rdata[BIT_PIN_LEVEL] == $past(pin_in); endproperty
    a_pin_level: assert property (p_pin_level) else $error("pin level wrong");
    property p_oe_write;
        reg_wr && reg_addr == OFS_CTRL_STATUS |->
            ##2 pin_oe == !$past(reg_wdata[BIT_DIRECTION], 2);
    endproperty
    a_oe_write: assert property (p_oe_write) else $error("direction not applied");
    property p_oe_reset; $fell(sys_rst) |-> ##[0:1] pin_oe; endproperty
    a_oe_reset: assert property (p_oe_reset) else $error("pin not output after reset");
    property p_irq_rise; $rose(pin_event_irq) |-> since_evt <= 4'h4; endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("summary rose without event");
    property p_irq_fall; $fell(pin_event_irq) |-> $past(reg_wr, 2) || $past(reg_wr, 3); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("summary fell without write");
endmodule
bind gpio_time_event_ctrl gpio_time_event_ctrl_asserts #(.NUM_PULSE(NUM_PULSE),
    .NUM_CAPTURE(NUM_CAPTURE)) chk_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pulse_fire(pulse_fire), .pulse_late(pulse_late),
    .capture_event(capture_event), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_event_irq(pin_event_irq));

/* File: tb/test_gpio_time_event_ctrl.sv */
// Self-checking bench for the pin event block with a pin load model.
// Assumes the package, interface and design files are compiled first.
module test_gpio_time_event_ctrl
    import time_event_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = 12'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic reg_wr = 1'b0, reg_rd = 1'b0, ext_level = 1'b0;
    logic pin_in, pin_out, pin_oe, pin_event_irq;
    logic [2:0] pulse_fire = 3'h0, pulse_late = 3'h0;
    logic [1:0] capture_event = 2'h0;
    int errors = 0, total_checks = 0;
    always #25 clk_sys = ~clk_sys;
    gpio_time_event_ctrl dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pulse_fire(pulse_fire), .pulse_late(pulse_late), .capture_event(capture_event),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_event_irq(pin_event_irq));
    pin_load load_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pin_in(pin_in));
    function automatic logic [31:0] bit_at(int n);
        return 32'h1 << n;
    endfunction
    function automatic logic [31:0] pulse_exp(int p, logic nt, int mode);
        return (nt && mode != 2) ? bit_at(PULSE_FLAG_LSB + p) : 32'h0;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata & m, exp);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #200000;
        errors++;
        complete_run();
    end
    initial begin
        logic nt;
        int mode, p;
        void'($urandom(32'h20f0));
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rdchk(OFS_IRQ_STATUS, 32'hffff_ffff, 32'h0);
        rdchk(OFS_CTRL_STATUS, 32'hffff_ff7f, 32'h0);
        rdchk(OFS_UNIT_TRIGGER, 32'hffff_ffff, 32'h0);
        check(pin_oe, 1'b1);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            nt = i[0];
            ext_level <= 1'($urandom_range(1, 0));
            wr(OFS_CTRL_STATUS, nt ? bit_at(BIT_DIRECTION) : 32'h0);
            rdchk(OFS_CTRL_STATUS, bit_at(BIT_DIRECTION), nt ? bit_at(BIT_DIRECTION) : 32'h0);
            check(pin_oe, !nt);
            if (nt) rdchk(OFS_CTRL_STATUS, bit_at(BIT_PIN_LEVEL), {24'h0, ext_level, 7'h0});
        end
        $display("test pin done");
        for (int u = 0; u < 2; u++) begin
            nt = 1'($urandom_range(1, 0));
            wr(OFS_UNIT_INDEX, u ? bit_at(BIT_CAP_SELECT) : 32'h0);
            wr(OFS_CTRL_STATUS, bit_at(BIT_DIRECTION) | bit_at(BIT_CAP_ARM)
                | (nt ? bit_at(BIT_CAP_IRQ_EN) : 32'h0));
            @(posedge clk_sys);
            capture_event <= 2'(1 << u);
            @(posedge clk_sys);
            capture_event <= 2'h0;
            repeat (3) @(posedge clk_sys);
            #1;
            check(pin_event_irq, nt);
            rdchk(OFS_IRQ_STATUS, 32'hffff_ffff, nt ? bit_at(u) : 32'h0);
            rdchk(OFS_CTRL_STATUS, 32'h22, bit_at(BIT_CAP_ARM) | (nt ? 32'h20 : 32'h0));
            rdchk(OFS_UNIT_CONFIG, 32'hfc, 32'h14);
            wr(OFS_IRQ_STATUS, bit_at(u));
            wr(OFS_CTRL_STATUS, bit_at(BIT_DIRECTION));
            rdchk(OFS_UNIT_CONFIG, 32'h0c, 32'h0);
            rdchk(OFS_IRQ_STATUS, 32'hffff_ffff, 32'h0);
        end
        $display("test capture done");
        for (int i = 0; i < 9; i++) begin
            p = i % 3;
            mode = $urandom_range(2, 0);
            nt = 1'($urandom_range(1, 0));
            wr(OFS_UNIT_INDEX, 32'(p));
            wr(OFS_UNIT_CONFIG, {31'h0, nt});
            wr(OFS_CTRL_STATUS, bit_at(BIT_PULSE_ARM));
            rdchk(OFS_CTRL_STATUS, 32'h18, 32'h18);
            if (mode == 2) begin
                wr(OFS_CTRL_STATUS, bit_at(BIT_SOFT_CLEAR) | bit_at(BIT_PULSE_ARM));
            end else begin
                @(posedge clk_sys);
                if (mode == 0) pulse_fire <= 3'(1 << p);
                else pulse_late <= 3'(1 << p);
                @(posedge clk_sys);
                pulse_fire <= 3'h0;
                pulse_late <= 3'h0;
                repeat (3) @(posedge clk_sys);
            end
            rdchk(OFS_CTRL_STATUS, mode == 1 ? 32'h10 : 32'h18, 32'h0);
            rdchk(OFS_IRQ_STATUS, 32'hffff_ffff, pulse_exp(p, nt, mode));
            wr(OFS_CTRL_STATUS, 32'h0);
            wr(OFS_IRQ_STATUS, 32'hffff_ffff);
            rdchk(OFS_IRQ_STATUS, 32'hffff_ffff, 32'h0);
        end
        $display("test pulse done");
        wr(OFS_UNIT_INDEX, {30'h0, PULSE_SEL_RESERVED});
        wr(OFS_CTRL_STATUS, bit_at(BIT_PULSE_ARM) | bit_at(BIT_OUT_SRC));
        rdchk(OFS_CTRL_STATUS, 32'h11c, bit_at(BIT_OUT_SRC));
        wr(OFS_UNIT_INDEX, 32'h0);
        rdchk(OFS_CTRL_STATUS, 32'h18, 32'h0);
        $display("test index done");
        wr(OFS_UNIT_CONFIG, bit_at(BIT_LEVEL));
        wr(OFS_CTRL_STATUS, bit_at(BIT_PULSE_ARM));
        @(posedge clk_sys);
        pulse_fire <= 3'h1;
        #1;
        check(pin_out, 1'b0);
        @(posedge clk_sys);
        pulse_fire <= 3'h0;
        repeat (3) @(posedge clk_sys);
        #1;
        check(pin_out, 1'b1);
        wr(OFS_CTRL_STATUS, bit_at(BIT_SOFT_CLEAR) | bit_at(BIT_OUT_SRC));
        repeat (2) @(posedge clk_sys);
        #1;
        check(pin_out, 1'b0);
        $display("test output done");
        complete_run();
    end
endmodule
